//--- rtl/blank_map.svh
// Functional notes
// R1: while falling-event blanking runs, rising-event inputs cannot trigger a rising event.
// R2: falling-event blanking starts when rising-event output drive deasserts.
// R3: falling-event blanking length is falling_blank_count generator clock periods.
// R4: falling_blank_count zero disables blanking; rising events pass straight through.
// R5: while rising-event blanking runs, falling-event inputs cannot trigger a falling event.
// R6: rising-event blanking starts when falling-event output drive deasserts.
// R7: rising-event blanking length is rising_blank_count generator clock periods.
// R8: rising_blank_count zero disables blanking; falling events pass straight through.
// R9: asynchronous trigger sources add at most one generator clock of uncertainty.
// R10: blanking time lies between count and count plus one clock periods.
// R11: each counter restarts on its start condition and releases after the count.
`ifndef BLANK_MAP_SVH
`define BLANK_MAP_SVH
`define BLANK_CNT_W 6
`define BLANK_CNT_RST 6'h00
`endif

//--- rtl/blank_pkg.sv
`include "blank_map.svh"
package blank_pkg;
    typedef logic [`BLANK_CNT_W-1:0] blank_cnt_t;
    typedef struct packed {
        logic rise;
        logic fall;
    } event_pair_t;
endpackage : blank_pkg

//--- rtl/edge_event_blanking_counters.sv
`timescale 1ns/1ps
`include "blank_map.svh"
module edge_event_blanking_counters (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire blank_pkg::blank_cnt_t falling_blank_count,
    input wire blank_pkg::blank_cnt_t rising_blank_count,
    input wire blank_pkg::event_pair_t event_in,
    input wire blank_pkg::event_pair_t drive,
    output blank_pkg::event_pair_t event_out,
    output blank_pkg::event_pair_t blank_active
);
    import blank_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // event inputs come from outside the clock domain: two flops
    event_pair_t sync1;
    event_pair_t sync2;
    event_pair_t drive_q;
    blank_cnt_t fall_cnt;
    blank_cnt_t rise_cnt;
    event_pair_t next_out;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (clk_en) begin
            sync1 <= event_in;
            sync2 <= sync1;
        end
    end

    // drive comes from logic on the same clock
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            drive_q <= '0;
        end else if (clk_en) begin
            drive_q <= drive;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // falling-event blanking counter, gates rising inputs
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fall_cnt <= `BLANK_CNT_RST;
        end else if (clk_en) begin
            if (drive_q.rise && !drive.rise) begin
                fall_cnt <= falling_blank_count; // R2 R3 R11
            end else if (fall_cnt != `BLANK_CNT_RST) begin
                fall_cnt <= fall_cnt - 1'h1; // R10 R11
            end
        end
    end

    // rising-event blanking counter, gates falling inputs
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rise_cnt <= `BLANK_CNT_RST;
        end else if (clk_en) begin
            if (drive_q.fall && !drive.fall) begin
                rise_cnt <= rising_blank_count; // R6 R7 R11
            end else if (rise_cnt != `BLANK_CNT_RST) begin
                rise_cnt <= rise_cnt - 1'h1; // R10 R11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // a zero count loads zero, so the gate stays open
    always_comb begin
        blank_active.rise = (fall_cnt != `BLANK_CNT_RST);
        blank_active.fall = (rise_cnt != `BLANK_CNT_RST);
        next_out.rise = sync2.rise && !blank_active.rise; // R1 R4
        next_out.fall = sync2.fall && !blank_active.fall; // R5 R8
    end

    // registered output keeps stage synchronous; sync adds the R9 slack
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            event_out <= '0;
        end else if (clk_en) begin
            event_out <= next_out; // R9
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_rise_blocked;
        @(posedge ref_clk) disable iff (srst)
            clk_en && fall_cnt != `BLANK_CNT_RST |=> !event_out.rise;
    endproperty
    a_rise_blocked: assert property (p_rise_blocked) // R1
        else $error("rising event passed during blanking");

    property p_fall_blocked;
        @(posedge ref_clk) disable iff (srst)
            clk_en && rise_cnt != `BLANK_CNT_RST |=> !event_out.fall;
    endproperty
    a_fall_blocked: assert property (p_fall_blocked) // R5
        else $error("falling event passed during blanking");

    property p_fall_start;
        @(posedge ref_clk) disable iff (srst)
            clk_en && drive_q.rise && !drive.rise |=> fall_cnt == $past(falling_blank_count);
    endproperty
    a_fall_start: assert property (p_fall_start) // R2
        else $error("falling blanking did not load");

    property p_rise_start;
        @(posedge ref_clk) disable iff (srst)
            clk_en && drive_q.fall && !drive.fall |=> rise_cnt == $past(rising_blank_count);
    endproperty
    a_rise_start: assert property (p_rise_start) // R6
        else $error("rising blanking did not load");

    property p_fall_len;
        @(posedge ref_clk) disable iff (srst)
            clk_en && fall_cnt == 6'h01 && !(drive_q.rise && !drive.rise)
            |=> fall_cnt == `BLANK_CNT_RST;
    endproperty
    a_fall_len: assert property (p_fall_len) // R3
        else $error("falling blanking did not end");

    property p_rise_len;
        @(posedge ref_clk) disable iff (srst)
            clk_en && rise_cnt == 6'h01 && !(drive_q.fall && !drive.fall)
            |=> rise_cnt == `BLANK_CNT_RST;
    endproperty
    a_rise_len: assert property (p_rise_len) // R7
        else $error("rising blanking did not end");

    property p_fall_zero;
        @(posedge ref_clk) disable iff (srst)
            clk_en && fall_cnt == `BLANK_CNT_RST && sync2.rise |=> event_out.rise;
    endproperty
    a_fall_zero: assert property (p_fall_zero) // R4
        else $error("rising event not passed with open gate");

    property p_rise_zero;
        @(posedge ref_clk) disable iff (srst)
            clk_en && rise_cnt == `BLANK_CNT_RST && sync2.fall |=> event_out.fall;
    endproperty
    a_rise_zero: assert property (p_rise_zero) // R8
        else $error("falling event not passed with open gate");

    property p_count_down;
        @(posedge ref_clk) disable iff (srst)
            clk_en && fall_cnt > 6'h01 && !(drive_q.rise && !drive.rise)
            |=> fall_cnt == $past(fall_cnt) - 6'h01 || !$past(clk_en);
    endproperty
    a_count_down: assert property (p_count_down) // R10
        else $error("falling counter stepped wrongly");

    property p_rise_count_down;
        @(posedge ref_clk) disable iff (srst)
            clk_en && rise_cnt > 6'h01 && !(drive_q.fall && !drive.fall)
            |=> rise_cnt == $past(rise_cnt) - 6'h01;
    endproperty
    a_rise_count_down: assert property (p_rise_count_down) // R10
        else $error("rising counter stepped wrongly");

    ////////////////////////////////////////////////////////////////////
    // a second deassertion mid-interval restarts the full count
    property p_fall_reload;
        @(posedge ref_clk) disable iff (srst)
            clk_en && fall_cnt != `BLANK_CNT_RST && drive_q.rise && !drive.rise
            |=> fall_cnt == $past(falling_blank_count);
    endproperty
    a_fall_reload: assert property (p_fall_reload) // R11
        else $error("falling blanking did not restart");

    property p_rise_reload;
        @(posedge ref_clk) disable iff (srst)
            clk_en && rise_cnt != `BLANK_CNT_RST && drive_q.fall && !drive.fall
            |=> rise_cnt == $past(rising_blank_count);
    endproperty
    a_rise_reload: assert property (p_rise_reload) // R11
        else $error("rising blanking did not restart");

    // a zero count loads zero, so the gate never closes
    property p_fall_zero_load;
        @(posedge ref_clk) disable iff (srst)
            clk_en && drive_q.rise && !drive.rise && falling_blank_count == `BLANK_CNT_RST
            |=> !blank_active.rise;
    endproperty
    a_fall_zero_load: assert property (p_fall_zero_load) // R4
        else $error("zero falling count still blanked");

    property p_rise_zero_load;
        @(posedge ref_clk) disable iff (srst)
            clk_en && drive_q.fall && !drive.fall && rising_blank_count == `BLANK_CNT_RST
            |=> !blank_active.fall;
    endproperty
    a_rise_zero_load: assert property (p_rise_zero_load) // R8
        else $error("zero rising count still blanked");

    ////////////////////////////////////////////////////////////////////
    // a frozen stage must not lose blanking time
    property p_fall_hold;
        @(posedge ref_clk) disable iff (srst)
            !clk_en |=> fall_cnt == $past(fall_cnt);
    endproperty
    a_fall_hold: assert property (p_fall_hold) // R3
        else $error("falling counter moved while frozen");

    property p_rise_hold;
        @(posedge ref_clk) disable iff (srst)
            !clk_en |=> rise_cnt == $past(rise_cnt);
    endproperty
    a_rise_hold: assert property (p_rise_hold) // R7
        else $error("rising counter moved while frozen");

    // frozen syncs keep the one-clock uncertainty bound
    property p_out_hold;
        @(posedge ref_clk) disable iff (srst)
            !clk_en |=> event_out == $past(event_out) && sync2 == $past(sync2);
    endproperty
    a_out_hold: assert property (p_out_hold) // R9
        else $error("event path moved while frozen");

    property p_sync_path;
        @(posedge ref_clk) disable iff (srst)
            clk_en |=> sync2 == $past(sync1);
    endproperty
    a_sync_path: assert property (p_sync_path) // R9
        else $error("synchroniser skipped a stage");

    // reset must leave both gates open and outputs quiet
    property p_reset_clear;
        @(posedge ref_clk)
            srst |=> event_out == 2'h0 && blank_active == 2'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) // R11
        else $error("outputs not cleared by reset");
endmodule : edge_event_blanking_counters

//--- tb/event_source.sv
`timescale 1ns/1ps
module event_source (
    input wire logic ref_clk,
    input wire blank_pkg::event_pair_t want,
    output blank_pkg::event_pair_t event_in
);
    // changes just after the edge, as a same-clock pwm source would
    always @(posedge ref_clk) begin
        event_in <= want;
    end
endmodule : event_source

//--- tb/test_edge_event_blanking_counters.sv
`timescale 1ns/1ps
module test_edge_event_blanking_counters;
    import blank_pkg::*;
    logic ref_clk = 0;
    logic srst = 1;
    logic clk_en = 1;
    blank_cnt_t falling_blank_count = '0;
    blank_cnt_t rising_blank_count = '0;
    event_pair_t want = '0;
    event_pair_t drive = '0;
    event_pair_t ev_in, ev_out, blank;
    int n_fail = 0;
    int checks = 0;
    logic [16:0] lf = 17'h1_7d12;
    ////////////////////////////////////////////////////////////////
    always #2.5 ref_clk = ~ref_clk;
    event_source src (.ref_clk(ref_clk), .want(want), .event_in(ev_in));
    edge_event_blanking_counters uut (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
        .falling_blank_count(falling_blank_count), .rising_blank_count(rising_blank_count),
        .event_in(ev_in), .drive(drive), .event_out(ev_out), .blank_active(blank));
    ////////////////////////////////////////////////////////////////
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    // a frozen stage stretches the blanking by the ten frozen edges
    function automatic int span_lo(input logic [5:0] n, input bit hold);
        return int'(n) + (hold ? 10 : 0);
    endfunction : span_lo
    // ch 1 is the rise channel, ch 0 the fall channel
    task automatic run(input int ch, input logic [5:0] n, input bit hold);
        int hits;
        int lo;
        logic [7:0] late;
        hits = 0;
        lo = span_lo(n, hold);
        late = '0;
        @(posedge ref_clk);
        falling_blank_count <= n;
        rising_blank_count <= n;
        drive <= 2'h3;
        want <= 2'h3;
        repeat (12) @(posedge ref_clk);
        drive <= (ch == 1) ? 2'h1 : 2'h2;
        for (int i = 0; i < 90; i++) begin
            @(posedge ref_clk);
            clk_en <= (hold && i >= 2 && i < 12) ? 1'h0 : 1'h1;
            #1;
            hits += int'(blank[ch] === 1'h1);
            if (i == 4 && n >= 8) check("gated event", 0, 8'(ev_out[ch]));
            if (i == lo + 9) late = 8'(ev_out[ch]);
        end
        check("blank span", 1, 8'(hits >= lo && hits <= lo + int'(n != 0)));
        check("release", 1, late);
    endtask : run
    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        for (int ch = 0; ch < 2; ch++) begin
            run(ch, 6'h00, 1'h0);
            run(ch, 6'h01, 1'h0);
            run(ch, 6'h3f, 1'h0);
            // odd draws drop clk_en in mid-interval
            for (int k = 0; k < 4; k++) begin
                lf = lfsr(lf);
                run(ch, 6'(8 + lf[5:0] % 56), k[0]);
            end
        end
        conclude();
    end
    // about 1500 cycles expected; far longer means a hang
    initial begin
        #50000;
        n_fail++;
        conclude();
    end
endmodule : test_edge_event_blanking_counters
